// file: bench/testbench.sv
`timescale 1ns/1ps
`include "uteh_regs.svh"
module testbench
    import uteh_pkg::*;
;
    logic clk, nrst, xact_start, cmd_valid, ep_isoch, desc_bad, desc_set_address, cmd_desc_bad;
    logic desc_err_to_hce, reset_ep_cmd, doorbell, interval_start, out_len_fits, out_req;
    logic port_enable_change_clr, xact_done, setup_accepted, retry_req, out_go, isoch_skip;
    logic host_controller_error_flag, port_enabled, port_enable_change_flag, event_valid;
    logic split_r, in_r;            // Extra report bits for the next send
    logic [1:0] error_retry_limit;
    uteh_spd_type ep_speed;
    uteh_xact_type cmd, xact;
    uteh_ep_type endpoint_state_field;
    uteh_event_type event_out;
    int miscompares, total_checks, cycles;
    uteh_res_type sres[4] = '{UTEH_RES_NAK, UTEH_RES_NYET, UTEH_RES_NAK, UTEH_RES_NRDY};
    uteh_spd_type sspd[4] = '{UTEH_SPD_HS, UTEH_SPD_HS, UTEH_SPD_FS, UTEH_SPD_SS};

    uteh_error_handler uut (.clk, .nrst, .xact_start, .xact_done, .xact, .error_retry_limit, .ep_isoch,
        .ep_speed, .desc_bad, .desc_set_address, .cmd_desc_bad, .desc_err_to_hce, .reset_ep_cmd, .doorbell,
        .setup_accepted, .interval_start, .out_len_fits, .out_req, .port_enable_change_clr,
        .endpoint_state_field, .retry_req, .out_go, .isoch_skip, .host_controller_error_flag, .port_enabled,
        .port_enable_change_flag, .event_out, .event_valid);
    uteh_dev_model dev (.clk, .nrst, .cmd_valid, .cmd, .xact_done, .xact, .setup_accepted);

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Inputs always move 1 ns after the edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic start(input logic [1:0] lim);
        error_retry_limit = lim;
        xact_start = 1'b1;
        tick();
        xact_start = 1'b0;
    endtask
    // Device report, then the edge at which the handler takes it
    task automatic send(input uteh_res_type r, input logic su, input logic [2:0] bab, input logic [15:0] n);
        cmd = '{res: r, is_setup: su, is_split_complete: split_r, is_in: in_r, babble_td: bab[2],
                babble_pkt: bab[1], babble_frame: bab[0], bytes_written: n};
        cmd_valid = 1'b1;
        tick();
        cmd_valid = 1'b0;
        tick();
    endtask
    task automatic ev(input logic v, input logic [7:0] code, input uteh_ep_type st);
        chk(event_valid, v);
        if (v)
            chk(event_out.code, code);
        chk(endpoint_state_field, st);
    endtask
    // Halted -> Stopped -> Running; the Stopped step must post a command event
    task automatic recover();
        reset_ep_cmd = 1'b1;
        tick();
        reset_ep_cmd = 1'b0;
        chk(endpoint_state_field, UTEH_EP_STOPPED);
        chk(event_out.kind, `UTEH_EV_COMMAND);
        doorbell = 1'b1;
        tick();
        doorbell = 1'b0;
        chk(endpoint_state_field, UTEH_EP_RUNNING);
    endtask
    task automatic do_reset(input int n);
        nrst = 1'b0;
        repeat (n) tick();
        nrst = 1'b1;
        tick();
    endtask
    // One pulse on a descriptor input, then compare
    task automatic dpulse(input int k, input logic [1:0] kind, input uteh_ep_type st);
        desc_bad = (k == 0);
        desc_set_address = (k == 1);
        cmd_desc_bad = (k == 2);
        tick();
        {desc_bad, desc_set_address, cmd_desc_bad} = 3'h0;
        ev(1'b1, 8'h05, st);
        chk(event_out.kind, kind);
    endtask

    initial begin
        {xact_start, cmd_valid, ep_isoch, desc_bad, desc_set_address, cmd_desc_bad, desc_err_to_hce} = 7'h00;
        {reset_ep_cmd, doorbell, interval_start, out_len_fits, out_req, port_enable_change_clr} = 6'h00;
        {split_r, in_r} = 2'h0;
        error_retry_limit = 2'h3;
        ep_speed = UTEH_SPD_HS;
        cmd = '0;
        do_reset(12);
        ev(1'b0, 8'h00, UTEH_EP_RUNNING);
        chk(port_enabled, 1'b1);
        chk({host_controller_error_flag, port_enable_change_flag}, 2'h0);
        // Two retries, third error reports and halts
        start(2'h3);
        repeat (2) begin
            send(UTEH_RES_CRC, 1'b0, 3'h0, 16'h0);
            chk({retry_req, event_valid}, 2'h2);
        end
        send(UTEH_RES_CRC, 1'b0, 3'h0, 16'h0);
        ev(1'b1, 8'h04, UTEH_EP_HALTED);
        chk(event_out.kind, `UTEH_EV_TRANSFER);
        recover();
        start(2'h1);
        send(UTEH_RES_ACK_RTY, 1'b0, 3'h0, 16'h0);
        ev(1'b1, 8'h04, UTEH_EP_HALTED);
        recover();
        // SETUP protocol errors, one retry left of two
        for (int i = 0; i < 4; i++) begin
            ep_speed = sspd[i];
            split_r = (i == 2);
            start(2'h2);
            send(sres[i], 1'b1, 3'h0, 16'h0);
            chk(retry_req, 1'b1);
            send(sres[i], 1'b1, 3'h0, 16'h0);
            ev(1'b1, 8'h04, UTEH_EP_HALTED);
            recover();
        end
        split_r = 1'b0;
        start(2'h3);
        send(UTEH_RES_TIMEOUT, 1'b0, 3'h0, 16'h0);
        ev(1'b1, 8'h04, UTEH_EP_HALTED);
        recover();
        ep_speed = UTEH_SPD_HS;
        start(2'h2);
        send(UTEH_RES_TIMEOUT, 1'b0, 3'h0, 16'h0);
        chk(retry_req, 1'b1);
        send(UTEH_RES_BADPID, 1'b0, 3'h0, 16'h0);
        ev(1'b1, 8'h04, UTEH_EP_HALTED);
        recover();
        ep_speed = UTEH_SPD_SS;
        send(UTEH_RES_BADPID, 1'b0, 3'h0, 16'h0);
        ev(1'b0, 8'h00, UTEH_EP_RUNNING);
        // Stall on a setup, then the device takes the next SETUP
        send(UTEH_RES_STALL, 1'b1, 3'h0, 16'h0);
        ev(1'b1, 8'h06, UTEH_EP_HALTED);
        send(UTEH_RES_OK, 1'b1, 3'h0, 16'h0);
        chk(endpoint_state_field, UTEH_EP_RUNNING);
        // Isochronous pipe halts on none of stall, CRC error or timeout
        ep_isoch = 1'b1;
        send(UTEH_RES_STALL, 1'b0, 3'h0, 16'h0);
        ev(1'b0, 8'h00, UTEH_EP_RUNNING);
        start(2'h3);
        send(UTEH_RES_CRC, 1'b0, 3'h0, 16'h0);
        ev(1'b1, 8'h04, UTEH_EP_RUNNING);
        send(UTEH_RES_TIMEOUT, 1'b0, 3'h0, 16'h0);
        chk({isoch_skip, retry_req}, 2'h2);
        interval_start = 1'b1;
        tick();
        interval_start = 1'b0;
        chk(isoch_skip, 1'b0);
        ep_isoch = 1'b0;
        // babble is never retried by the bench
        // One error spent before each babble; the babble must leave the budget alone
        for (int b = 0; b < 3; b++) begin
            start(2'h3);
            send(UTEH_RES_CRC, 1'b0, 3'h0, 16'h0);
            send(UTEH_RES_OK, 1'b0, 3'(1 << b), 16'h0040 + 16'(b));
            ev(1'b1, 8'h03, UTEH_EP_HALTED);
            chk({retry_req, event_out.length}, {1'b0, 16'h0040 + 16'(b)});
            chk(port_enabled, 1'b1);
            recover();
            send(UTEH_RES_CRC, 1'b0, 3'h0, 16'h0);
            chk(retry_req, 1'b1);
        end
        in_r = 1'b1;
        send(UTEH_RES_OK, 1'b0, 3'h1, 16'h0010);
        ev(1'b1, 8'h03, UTEH_EP_HALTED);
        chk({port_enabled, port_enable_change_flag}, 2'h1);
        port_enable_change_clr = 1'b1;
        tick();
        port_enable_change_clr = 1'b0;
        chk(port_enable_change_flag, 1'b0);
        chk({event_valid, event_out.kind}, {1'b1, `UTEH_EV_PORT});
        recover();
        // OUT held back while it would cross the frame end
        out_req = 1'b1;
        repeat (2) tick();
        chk(out_go, 1'b0);
        out_len_fits = 1'b1;
        repeat (2) tick();
        chk(out_go, 1'b1);
        out_req = 1'b0;
        // descriptor faults only where the bench pulses them
        dpulse(0, `UTEH_EV_TRANSFER, UTEH_EP_ERROR);
        do_reset(2);
        dpulse(1, `UTEH_EV_TRANSFER, UTEH_EP_ERROR);
        do_reset(2);
        dpulse(2, `UTEH_EV_COMMAND, UTEH_EP_RUNNING);
        desc_err_to_hce = 1'b1;
        desc_bad = 1'b1;
        tick();
        desc_bad = 1'b0;
        chk({host_controller_error_flag, endpoint_state_field}, {1'b1, UTEH_EP_RUNNING});
        end_of_test();
    end
endmodule

// file: bench/uteh_dev_model.sv
`timescale 1ns/1ps
module uteh_dev_model
    import uteh_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_valid,      // Bench orders one outcome
    input wire uteh_xact_type cmd,   // Outcome the device will give
    output logic xact_done,          // One-cycle report
    output uteh_xact_type xact,      // Report contents
    output logic setup_accepted      // Device took a SETUP
);
    // Answer one cycle after the order; between reports the content churns
    // so a stale value can never pass for a fresh one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xact_done <= 1'b0;
            xact <= '0;
            setup_accepted <= 1'b0;
        end else if (cmd_valid) begin
            xact_done <= 1'b1;
            xact <= cmd;
            setup_accepted <= cmd.is_setup && (cmd.res == UTEH_RES_OK);
        end else begin
            xact_done <= 1'b0;
            xact <= uteh_xact_type'(~xact);
            setup_accepted <= 1'b0;
        end
    end
endmodule

// file: hw/uteh_error_handler.sv
`timescale 1ns/1ps
`include "uteh_regs.svh"
module uteh_error_handler
    import uteh_pkg::*;
#(
    parameter int CNT_W = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic xact_start,                // Transaction begins, loads counter
    input wire logic xact_done,                 // Transaction outcome valid
    input wire uteh_xact_type xact,             // Outcome details
    input wire logic [CNT_W-1:0] error_retry_limit,
    input wire logic ep_isoch,                  // Endpoint is isochronous
    input wire uteh_spd_type ep_speed,          // Device speed
    input wire logic desc_bad,                  // Malformed transfer descriptor
    input wire logic desc_set_address,          // Setup stage carries address request
    input wire logic cmd_desc_bad,              // Malformed command descriptor
    input wire logic desc_err_to_hce,           // Use error flag instead of Error state
    input wire logic reset_ep_cmd,              // Reset-endpoint command
    input wire logic doorbell,                  // Endpoint doorbell write
    input wire logic setup_accepted,            // Device took next SETUP
    input wire logic interval_start,            // New isoch service interval
    input wire logic out_len_fits,              // OUT fits before microframe end
    input wire logic out_req,                   // OUT transaction wanted
    input wire logic port_enable_change_clr,    // Software clears change flag
    output uteh_ep_type endpoint_state_field,
    output logic retry_req,                     // Retry current transaction
    output logic out_go,                        // OUT may start
    output logic isoch_skip,                    // Isoch paused to next interval
    output logic host_controller_error_flag,
    output logic port_enabled,
    output logic port_enable_change_flag,
    output uteh_event_type event_out,
    output logic event_valid
);
    // Elaboration guard: the bus error counter must be exactly two bits;
    // a wider one would only widen the range of limits, a limit still allows limit minus one retries
    if (CNT_W != 2) begin : g_cnt_w_check
        $error("bus error counter must be two bits");
    end

    // State registers
    uteh_ep_type ep_r, ep_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;           // Bus error down counter
    logic retry_r, retry_nxt;
    logic go_r, go_nxt;
    logic skip_r, skip_nxt;
    logic hce_r, hce_nxt;
    logic pen_r, pen_nxt;
    logic pec_r, pec_nxt;
    uteh_event_type ev_r, ev_nxt;
    logic evv_r, evv_nxt;
    // Port change event owed after an IN frame babble; it waits for a cycle
    // in which no other event is posted, so no completion is ever lost
    logic pev_r, pev_nxt;
    // Decode helpers, recomputed every cycle
    logic err_class;                            // Retryable error seen
    logic ss_timeout; // SuperSpeed timeout, never retried
    logic ev_busy; // Some other event already owns this cycle

    // Next-state computation
    // Requests are taken in a fixed priority: reset-endpoint command, doorbell,
    // accepted SETUP, command descriptor fault, transfer descriptor fault, and
    // last the transaction outcome. Only one of them moves the endpoint state
    // in a cycle; a lower one arriving together with a higher one is dropped,
    // so software and the link side must not pile them into one cycle.
    // Outcomes are only acted on while Running: a report that lands while the
    // ring is Halted or Stopped belongs to a pipe that is already out of the
    // schedule and is ignored.
    always_comb begin
        ep_nxt = ep_r;
        cnt_nxt = cnt_r;
        retry_nxt = 1'b0;
        skip_nxt = skip_r;
        hce_nxt = hce_r;
        pen_nxt = pen_r;
        pec_nxt = pec_r;
        ev_nxt = ev_r;
        evv_nxt = 1'b0;
        pev_nxt = pev_r;
        // One cycle late; the requester holds out_req until out_go
        // OUT boundary gate
        go_nxt = out_req && out_len_fits && ep_r == UTEH_EP_RUNNING && !skip_r;
        // Error classes that spend the retry budget. A SuperSpeed timeout is
        // split off below because it halts at once instead of retrying
        // error classes; bad PID is USB2 only
        err_class = xact.res == UTEH_RES_CRC || xact.res == UTEH_RES_ACK_RTY
            || (xact.res == UTEH_RES_BADPID && ep_speed != UTEH_SPD_SS)
            || (xact.res == UTEH_RES_TIMEOUT && ep_speed != UTEH_SPD_SS)
            || (xact.is_setup && ep_speed == UTEH_SPD_HS
                && (xact.res == UTEH_RES_NAK || xact.res == UTEH_RES_NYET))
            || (xact.is_setup && xact.is_split_complete && xact.res == UTEH_RES_NAK)
            || (xact.is_setup && ep_speed == UTEH_SPD_SS && xact.res == UTEH_RES_NRDY);
        ss_timeout = xact.res == UTEH_RES_TIMEOUT && ep_speed == UTEH_SPD_SS;
        // Isoch pause ends at next interval
        if (interval_start) begin
            skip_nxt = 1'b0;
        end
        if (xact_start) begin
            cnt_nxt = error_retry_limit;
        end
        if (reset_ep_cmd && ep_r == UTEH_EP_HALTED) begin
            ep_nxt = UTEH_EP_STOPPED;
            ev_nxt = '{kind: `UTEH_EV_COMMAND, code: `UTEH_CC_SUCCESS, length: `UTEH_LEN_RST};
            evv_nxt = 1'b1;
        end else if (doorbell && ep_r == UTEH_EP_STOPPED) begin
            // Doorbell restarts a Stopped ring
            ep_nxt = UTEH_EP_RUNNING;
        end else if (setup_accepted && ep_r == UTEH_EP_HALTED) begin
            // control halt cleared by accepted SETUP
            ep_nxt = UTEH_EP_RUNNING;
        end else if (cmd_desc_bad) begin
            // command descriptor errors in completion event
            ev_nxt = '{kind: `UTEH_EV_COMMAND, code: `UTEH_CC_DESC, length: `UTEH_LEN_RST};
            evv_nxt = 1'b1;
        end else if (desc_bad || desc_set_address) begin
            // descriptor error, Error state or flag
            ev_nxt = '{kind: `UTEH_EV_TRANSFER, code: `UTEH_CC_DESC, length: `UTEH_LEN_RST};
            evv_nxt = 1'b1;
            if (desc_err_to_hce) begin
                // Cheaper option: flag the controller, leave the ring alone
                hce_nxt = 1'b1;
            end else begin
                // Preferred option: park the endpoint in Error
                ep_nxt = UTEH_EP_ERROR;
            end
        end else if (xact_done && ep_r == UTEH_EP_RUNNING) begin
            // Outcome events are always transfer events
            ev_nxt.kind = `UTEH_EV_TRANSFER;
            ev_nxt.length = xact.bytes_written;
            if (xact.babble_td || xact.babble_pkt || xact.babble_frame) begin
                // babble: halt, no count, no retry
                ev_nxt.code = `UTEH_CC_BABBLE;
                evv_nxt = 1'b1;
                ep_nxt = UTEH_EP_HALTED;
                if (xact.babble_frame && xact.is_in && pen_r) begin
                    pen_nxt = 1'b0;
                    pec_nxt = 1'b1;
                    pev_nxt = 1'b1;
                end
            end else if (xact.res == UTEH_RES_STALL && !ep_isoch) begin
                ev_nxt.code = `UTEH_CC_STALL;
                evv_nxt = 1'b1;
                ep_nxt = UTEH_EP_HALTED;
            end else if (ss_timeout) begin
                ev_nxt.code = `UTEH_CC_XACT;
                evv_nxt = 1'b1;
                if (ep_isoch) begin
                    // Isoch waits for the next interval instead of halting
                    skip_nxt = 1'b1;
                end else begin
                    ep_nxt = UTEH_EP_HALTED;
                end
            end else if (err_class) begin
                if (ep_isoch) begin
                    // Isoch pipes do not halt on these errors, error goes out at once
                    ev_nxt.code = `UTEH_CC_XACT;
                    evv_nxt = 1'b1;
                end else if (cnt_r <= CNT_W'(1)) begin
                    cnt_nxt = `UTEH_CNT_RST;
                    ev_nxt.code = `UTEH_CC_XACT;
                    evv_nxt = 1'b1;
                    ep_nxt = UTEH_EP_HALTED;
                end else begin
                    // Budget left: count down and ask for a retry
                    cnt_nxt = cnt_r - CNT_W'(1);
                    retry_nxt = 1'b1;
                end
            end else if (xact.res == UTEH_RES_OK) begin
                // Success refills the budget for the next transaction
                cnt_nxt = error_retry_limit;
            end
        end
        // A clear landing with a fresh frame babble would hide it from software
        // set wins over clear
        if (port_enable_change_clr && !(pec_nxt && !pec_r)) begin
            pec_nxt = 1'b0;
        end
        // It takes the first cycle with no other event, so none is overwritten
        // owed port change event
        ev_busy = evv_nxt;
        if (pev_r && !ev_busy) begin
            ev_nxt = '{kind: `UTEH_EV_PORT, code: `UTEH_CC_SUCCESS, length: `UTEH_LEN_RST};
            evv_nxt = 1'b1;
            pev_nxt = 1'b0;
        end
    end

    // Registers only
    // Reset leaves the endpoint Running with an empty counter: a transfer
    // must begin with a start pulse to load the retry budget
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ep_r <= UTEH_EP_RUNNING;
            cnt_r <= `UTEH_CNT_RST;
            retry_r <= 1'b0;
            go_r <= 1'b0;
            skip_r <= 1'b0;
            hce_r <= 1'b0;
            pen_r <= 1'b1;
            pec_r <= 1'b0;
            ev_r <= '0;
            evv_r <= 1'b0;
            pev_r <= 1'b0;
        end else begin
            ep_r <= ep_nxt;
            cnt_r <= cnt_nxt;
            retry_r <= retry_nxt;
            go_r <= go_nxt;
            skip_r <= skip_nxt;
            hce_r <= hce_nxt;
            pen_r <= pen_nxt;
            pec_r <= pec_nxt;
            ev_r <= ev_nxt;
            evv_r <= evv_nxt;
            pev_r <= pev_nxt;
        end
    end

    // Every output is a register copy, so nothing combinational reaches a pin
    assign endpoint_state_field = ep_r;
    assign retry_req = retry_r;
    assign out_go = go_r;
    assign isoch_skip = skip_r;
    assign host_controller_error_flag = hce_r;
    assign port_enabled = pen_r;
    assign port_enable_change_flag = pec_r;
    assign event_out = ev_r;
    assign event_valid = evv_r;

    // Checks
    // Properties check the registers; some start from the inputs and look one
    // edge later, the rest relate register values within one cycle or to $past.
    // Reset disables them all; the first edge after release sees reset values
    // in any past term of a register.
    property p_no_isoch_stall;
        @(posedge clk) disable iff (!nrst) ep_isoch ##1 evv_r |-> ev_r.code != `UTEH_CC_STALL;
    endproperty
    a_no_isoch_stall: assert property (p_no_isoch_stall) else $error("stall on isoch");
    property p_stall_halts;
        @(posedge clk) disable iff (!nrst)
        xact_done && ep_r == UTEH_EP_RUNNING && xact.res == UTEH_RES_STALL && !ep_isoch
        && !xact.babble_td && !xact.babble_pkt && !xact.babble_frame && !reset_ep_cmd && !doorbell
        && !setup_accepted && !cmd_desc_bad && !desc_bad && !desc_set_address
        |=> ep_r == UTEH_EP_HALTED && evv_r && ev_r.code == `UTEH_CC_STALL;
    endproperty
    a_stall_halts: assert property (p_stall_halts) else $error("stall did not halt");
    property p_xact_code_kind;
        @(posedge clk) disable iff (!nrst)
        evv_r && (ev_r.code == `UTEH_CC_XACT || ev_r.code == `UTEH_CC_BABBLE) |-> ev_r.kind == `UTEH_EV_TRANSFER;
    endproperty
    a_xact_code_kind: assert property (p_xact_code_kind) else $error("bad event kind");
    property p_desc_kind;
        @(posedge clk) disable iff (!nrst)
        evv_r && ev_r.code == `UTEH_CC_DESC |-> ev_r.kind != `UTEH_EV_PORT;
    endproperty
    a_desc_kind: assert property (p_desc_kind) else $error("descriptor error kind");
    property p_babble_len;
        @(posedge clk) disable iff (!nrst)
        evv_r && ev_r.code == `UTEH_CC_BABBLE |-> ev_r.length == $past(xact.bytes_written)
        && ep_r == UTEH_EP_HALTED && !retry_r && cnt_r == $past(cnt_r);
    endproperty
    a_babble_len: assert property (p_babble_len) else $error("babble handling");
    property p_out_gate;
        @(posedge clk) disable iff (!nrst) go_r |-> $past(out_len_fits) && $past(out_req);
    endproperty
    a_out_gate: assert property (p_out_gate) else $error("OUT across frame end");
    property p_port_off;
        @(posedge clk) disable iff (!nrst) $fell(pen_r) |-> pec_r && ev_r.code == `UTEH_CC_BABBLE && pev_r;
    endproperty
    a_port_off: assert property (p_port_off) else $error("port disable");
    property p_port_event;
        @(posedge clk) disable iff (!nrst)
        pev_r && !ev_busy |=> evv_r && ev_r.kind == `UTEH_EV_PORT && ev_r.code == `UTEH_CC_SUCCESS;
    endproperty
    a_port_event: assert property (p_port_event) else $error("port change event missing");
    property p_reset_ep;
        @(posedge clk) disable iff (!nrst)
        ep_r == UTEH_EP_HALTED && reset_ep_cmd ##1 doorbell && !reset_ep_cmd
        |-> ep_r == UTEH_EP_STOPPED ##1 ep_r == UTEH_EP_RUNNING;
    endproperty
    a_reset_ep: assert property (p_reset_ep) else $error("reset-endpoint flow");
    property p_retry_dec;
        @(posedge clk) disable iff (!nrst) retry_r |-> cnt_r == $past(cnt_r) - CNT_W'(1);
    endproperty
    a_retry_dec: assert property (p_retry_dec) else $error("retry without decrement");
    c_babble: cover property (@(posedge clk) evv_r && ev_r.code == `UTEH_CC_BABBLE);
    c_xact: cover property (@(posedge clk) evv_r && ev_r.code == `UTEH_CC_XACT && ep_r == UTEH_EP_HALTED);
    c_retry: cover property (@(posedge clk) retry_r ##1 retry_r);
    c_skip: cover property (@(posedge clk) skip_r);
    c_port_event: cover property (@(posedge clk) evv_r && ev_r.kind == `UTEH_EV_PORT);
endmodule

// file: hw/uteh_pkg.sv
package uteh_pkg;
    // Endpoint context states
    typedef enum logic [2:0] {
        UTEH_EP_DISABLED, UTEH_EP_RUNNING, UTEH_EP_HALTED, UTEH_EP_STOPPED, UTEH_EP_ERROR
    } uteh_ep_type;
    // Transaction outcome seen on the bus
    typedef enum logic [3:0] {
        UTEH_RES_OK, UTEH_RES_STALL, UTEH_RES_CRC, UTEH_RES_TIMEOUT, UTEH_RES_BADPID,
        UTEH_RES_NAK, UTEH_RES_NYET, UTEH_RES_NRDY, UTEH_RES_ACK_RTY
    } uteh_res_type;
    typedef enum logic [1:0] {UTEH_SPD_LS, UTEH_SPD_FS, UTEH_SPD_HS, UTEH_SPD_SS} uteh_spd_type;
    // One finished transaction report
    typedef struct packed {
        uteh_res_type res;
        logic is_setup;
        logic is_split_complete;
        logic is_in;
        logic babble_td;
        logic babble_pkt;
        logic babble_frame;
        logic [15:0] bytes_written;
    } uteh_xact_type;
    // One event posted
    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] code;
        logic [15:0] length;
    } uteh_event_type;
endpackage

// file: hw/uteh_regs.svh
`ifndef UTEH_REGS_SVH
`define UTEH_REGS_SVH
// How it works
// - Never report stall on isochronous endpoint
// - Descriptor error only in transfer/command completion
// - Transfer descriptor error sets endpoint Error state
// - SETUP protocol errors decrement bus error counter
// - CRC/data packet errors retried to limit
// - ACK on retry-flagged data packet is error
// - SuperSpeed timeout halts at once, USB2 retries
// - Isoch SuperSpeed timeout skips rest of interval
// - Bad PID retried, USB2 only
// - Isoch errors reported immediately, others halt
// - Transaction and babble codes only in transfers
// - Babble sets code, event, halts endpoint
// - Babble neither decrements counter nor retries
// - Babble length equals bytes actually written
// - EOF2 IN frame babble disables root port
// - Never start OUT crossing microframe end
// - IN frame babble disables port, sets change flag
// - Address request in setup is descriptor error
// - Stall halts endpoint with stall event
// - Reset command to Stopped, doorbell to Running
// - Bus error counter is two-bit down counter

// Completion codes
`define UTEH_CC_SUCCESS 8'h01
`define UTEH_CC_BABBLE 8'h03
`define UTEH_CC_XACT 8'h04
`define UTEH_CC_DESC 8'h05
`define UTEH_CC_STALL 8'h06
// Event kinds
`define UTEH_EV_NONE 2'h0
`define UTEH_EV_TRANSFER 2'h1
`define UTEH_EV_COMMAND 2'h2
`define UTEH_EV_PORT 2'h3
// Counter reset value
`define UTEH_CNT_RST 2'h0
`define UTEH_LEN_RST 16'h0000
`endif
